//--- bench/ccc_testbench.sv
// Self-checking testbench for the capture clock calibrator.
`timescale 1ns/1ps
`default_nettype none

module testbench import ccc_pkg::*;;
    logic i_sys_clk, i_resetn, i_fast_capture_clock, i_wr_stb, i_rd_stb, rd_d;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata;
    logic o_irq;
    logic [DATA_W-1:0] exp_q[$]; // Expected read data, oldest first.
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int k;
    logic [DATA_W-1:0] per;
    logic [ADDR_W-1:0] rd_a; // Address of the read whose data stands now.
    logic [DATA_W-1:0] sys_seen, fast_seen; // Last captures read, for the software math.

    ccc_calibrator u_ccc_calibrator (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_fast_capture_clock(i_fast_capture_clock), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rdata(o_rdata), .o_irq(o_irq));

    // Clock at 25 MHz.
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    // Fast pin rises every 4 cycles, so an interval of 4k cycles holds exactly k rises.
    initial begin
        i_fast_capture_clock = 1'b0;
        forever begin
            repeat (2) @(posedge i_sys_clk);
            i_fast_capture_clock <= ~i_fast_capture_clock;
        end
    end

    // Compares a seen value with an expected one and counts the result.
    task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_sys_clk);
        i_wr_stb <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr_stb <= 1'b0;
    endtask

    // One-cycle read strobe; the expectation goes to the queue for the monitor.
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge i_sys_clk);
        i_rd_stb <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_sys_clk);
        i_rd_stb <= 1'b0;
    endtask

    // Looks at the interrupt once updates from the last write have landed.
    task automatic chk_irq(input logic e);
        repeat (2) @(negedge i_sys_clk);
        chk("irq", {31'h0, o_irq}, {31'h0, e});
    endtask

    // Waits a bounded time for the interrupt to rise.
    task automatic wait_irq();
        int n;
        n = 0;
        while (o_irq !== 1'b1 && n < 200) begin
            @(negedge i_sys_clk);
            n++;
        end
        chk("irq", {31'h0, o_irq}, 32'h1);
    endtask

    // Read data stands only in the cycle after the strobe, so it is sampled mid-cycle.
    always @(posedge i_sys_clk) begin
        rd_d <= i_rd_stb;
        rd_a <= i_addr;
    end
    always @(negedge i_sys_clk) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) begin
            if (rd_a == OFS_SYS_CAP) begin
                sys_seen = o_rdata;
            end
            if (rd_a == OFS_FAST_CAP) begin
                fast_seen = o_rdata;
            end
            chk("rdata", o_rdata, exp_q.pop_front());
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the fewer than two hundred cycles the tests need.
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        i_resetn = 1'b0;
        {i_wr_stb, i_rd_stb, i_addr, i_wdata} = '0;
        void'($urandom(18453));
        repeat (2) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        // Reset values, a read-only write and an unmapped address.
        rd(OFS_PERIOD, PERIOD_RST);
        rd(OFS_INT_MASK, 32'h0);
        wr(OFS_SYS_CAP, 32'h1234_5678);
        rd(OFS_SYS_CAP, 32'h0);
        rd(OFS_FAST_CAP, 32'h0);
        rd(OFS_INT_STATUS, 32'h0);
        rd(8'h1c, 32'h0);
        // Live counts: cycles since release, and pin rises that land four edges late.
        rd(OFS_SYS_LIVE, 32'h0000_000f);
        rd(OFS_FAST_LIVE, 32'h0000_0004);
        $display("test reset_values done");
        // Reset again mid-run; period 4k-1 keeps the interval at 4k cycles.
        @(posedge i_sys_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        k = 6 + ($urandom % 5);
        per = DATA_W'(4 * k - 1);
        wr(OFS_PERIOD, per);
        repeat (4 * k) @(posedge i_sys_clk);
        rd(OFS_INT_STATUS, 32'h1);
        chk_irq(1'b0);
        wr(OFS_INT_MASK, 32'h1);
        chk_irq(1'b1);
        wr(OFS_INT_STATUS, 32'h1);
        chk_irq(1'b0);
        $display("test mask_and_clear done");
        // A full interval: both captures of the same window.
        wait_irq();
        rd(OFS_SYS_CAP, per);
        rd(OFS_FAST_CAP, DATA_W'(k));
        rd(OFS_PERIOD, per);
        rd(OFS_INT_STATUS, 32'h1);
        // The handler turns the fresh pair into a scale and a time for k fast periods.
        chk("scale", sys_seen / fast_seen, per / k);
        chk("time_ns", DATA_W'(k) * 32'h80 * sys_seen / fast_seen / 32'h80 * 32'h28, per * 32'h28);
        // Left uncleared, the flag sticks and the next match marks an overrun.
        repeat (4 * k) @(posedge i_sys_clk);
        rd(OFS_INT_STATUS, 32'h3);
        rd(OFS_SYS_CAP, per);
        rd(OFS_FAST_CAP, DATA_W'(k));
        chk_irq(1'b1);
        $display("test capture_interval done");
        repeat (3) @(posedge i_sys_clk);
        complete_run();
    end
endmodule

`default_nettype wire

//--- pkg/ccc_pkg.sv
// Package holding the register map, field positions and reset values of the capture clock calibrator.
// Functional notes
// - Count every fast capture clock edge freely.
// - Count every system clock cycle in parallel.
// - Detect system count equal to calibration period.
// - On match, capture both counts, then clear.
// - Raise calibration interrupt after the capture.
`default_nettype none

package ccc_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Default counter width; each counter and capture register is this wide.
    localparam int CNT_W_DEF = 32;

    // Register byte offsets, one aligned word each.
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SYS_CAP = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FAST_CAP = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SYS_LIVE = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FAST_LIVE = 8'h18;

    // Interrupt status and mask field positions.
    localparam int INT_W = 2;
    localparam int BIT_CAL_DONE = 0;
    localparam int BIT_OVERRUN = 1;

    // Reset values.
    localparam logic [DATA_W-1:0] PERIOD_RST = 32'h0000_ffff;
    localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;

endpackage

`default_nettype wire

//--- verilog/ccc_calibrator.sv
// Capture clock calibrator: two free-running counters, period match capture and interrupt.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ccc_calibrator
    import ccc_pkg::*;
#(
    parameter int CNT_W = CNT_W_DEF
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_fast_capture_clock,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_irq
);

    // Rising edge of the fast clock seen in the system domain.
    // The pin is sampled, so its rate must stay below half the system rate.
    logic fast_edge;

    // Free-running counters.
    logic [CNT_W-1:0] fast_cnt_r;
    logic [CNT_W-1:0] fast_cnt_nxt;
    logic [CNT_W-1:0] sys_cnt_r;
    logic [CNT_W-1:0] sys_cnt_nxt;

    // Captured counts and the programmed period.
    logic [CNT_W-1:0] sys_cap_r;
    logic [CNT_W-1:0] sys_cap_nxt;
    logic [CNT_W-1:0] fast_cap_r;
    logic [CNT_W-1:0] fast_cap_nxt;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] period_nxt;

    // Interrupt state.
    logic [INT_W-1:0] status_r;
    logic [INT_W-1:0] status_nxt;
    logic [INT_W-1:0] mask_r;
    logic [INT_W-1:0] mask_nxt;
    logic irq_r;
    logic irq_nxt;

    // Read data register.
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    // Decoded strobes.
    logic period_hit;
    logic wr_period;
    logic wr_status;
    logic wr_mask;

    // The pin crosses into the system domain before any counting logic sees it.
    ccc_edge_sync u_edge_sync (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_async(i_fast_capture_clock),
        .o_rise(fast_edge)
    );

    // Match and write decode.
    always_comb begin
        period_hit = (sys_cnt_r == period_r);
        wr_period = i_wr_stb && (i_addr == OFS_PERIOD);
        wr_status = i_wr_stb && (i_addr == OFS_INT_STATUS);
        wr_mask = i_wr_stb && (i_addr == OFS_INT_MASK);
    end

    // Counter and capture next values.
    always_comb begin
        fast_cnt_nxt = fast_cnt_r;
        sys_cnt_nxt = sys_cnt_r;
        sys_cap_nxt = sys_cap_r;
        fast_cap_nxt = fast_cap_r;
        if (period_hit) begin
            // Capture the counts as they stand, then restart the interval.
            sys_cap_nxt = sys_cnt_r;
            fast_cap_nxt = fast_cnt_r;
            sys_cnt_nxt = '0;
            // An edge landing in the match cycle opens the new interval, so it is not lost.
            fast_cnt_nxt = fast_edge ? CNT_W'(1) : '0;
        end else begin
            sys_cnt_nxt = sys_cnt_r + 1'b1;
            if (fast_edge) begin
                fast_cnt_nxt = fast_cnt_r + 1'b1;
            end
        end
    end

    // Register writes and interrupt next values.
    always_comb begin
        period_nxt = period_r;
        mask_nxt = mask_r;
        if (wr_period) begin
            period_nxt = i_wdata[CNT_W-1:0];
        end
        if (wr_mask) begin
            mask_nxt = i_wdata[INT_W-1:0];
        end
        // Writing one clears a bit; a set in the same cycle wins over the clear.
        status_nxt = status_r;
        if (wr_status) begin
            status_nxt = status_r & ~i_wdata[INT_W-1:0];
        end
        if (period_hit) begin
            status_nxt[BIT_CAL_DONE] = 1'b1;
            // A capture while the previous one is still unserviced overwrites it.
            status_nxt[BIT_OVERRUN] = status_r[BIT_CAL_DONE] | status_nxt[BIT_OVERRUN];
        end
        // Computed from next values so the output is a flop yet tracks the status.
        irq_nxt = |(status_nxt & mask_nxt);
    end

    // Read mux; data stand only in the cycle after the read strobe.
    always_comb begin
        rdata_nxt = '0;
        if (i_rd_stb) begin
            case (i_addr)
                OFS_PERIOD: rdata_nxt[CNT_W-1:0] = period_r;
                OFS_SYS_CAP: rdata_nxt[CNT_W-1:0] = sys_cap_r;
                OFS_FAST_CAP: rdata_nxt[CNT_W-1:0] = fast_cap_r;
                OFS_INT_STATUS: rdata_nxt[INT_W-1:0] = status_r;
                OFS_INT_MASK: rdata_nxt[INT_W-1:0] = mask_r;
                OFS_SYS_LIVE: rdata_nxt[CNT_W-1:0] = sys_cnt_r;
                OFS_FAST_LIVE: rdata_nxt[CNT_W-1:0] = fast_cnt_r;
                // Unmapped offsets read as zero.
                default: rdata_nxt = '0;
            endcase
        end
    end

    // State registers; every one clears to a constant.
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fast_cnt_r <= '0;
            sys_cnt_r <= '0;
            sys_cap_r <= '0;
            fast_cap_r <= '0;
            period_r <= PERIOD_RST[CNT_W-1:0];
            status_r <= '0;
            mask_r <= INT_MASK_RST;
            irq_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            fast_cnt_r <= fast_cnt_nxt;
            sys_cnt_r <= sys_cnt_nxt;
            sys_cap_r <= sys_cap_nxt;
            fast_cap_r <= fast_cap_nxt;
            period_r <= period_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_irq = irq_r;

    // Checks on the behaviour above, all on the system clock.
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);

    // Clear write of the done flag, used to qualify stickiness.
    logic clr_done;
    assign clr_done = wr_status && i_wdata[BIT_CAL_DONE];

    a_fast_count_step: assert property (
        (fast_edge && !period_hit) |=> (fast_cnt_r == $past(fast_cnt_r) + 1'b1))
        else $error("Fast counter missed an edge.");

    a_fast_count_hold: assert property (
        (!fast_edge && !period_hit) |=> $stable(fast_cnt_r))
        else $error("Fast counter moved without an edge.");

    a_sys_count_step: assert property (
        !period_hit |=> (sys_cnt_r == $past(sys_cnt_r) + 1'b1))
        else $error("System counter did not advance.");

    // A period of zero matches again at once, so the counter may legally stay at zero.
    a_period_match_restart: assert property (
        (sys_cnt_r == period_r) |=> (sys_cnt_r == '0)
            ##1 (sys_cnt_r == ($past(period_hit) ? '0 : CNT_W'(1))))
        else $error("Match did not restart the system counter.");

    a_capture_on_match: assert property (
        period_hit |=> (sys_cap_r == $past(sys_cnt_r)) && (fast_cap_r == $past(fast_cnt_r))
                       && (fast_cnt_r <= CNT_W'(1)))
        else $error("Counts not captured and cleared on match.");

    a_irq_after_capture: assert property (
        (period_hit && mask_r[BIT_CAL_DONE] && !wr_mask) |=> status_r[BIT_CAL_DONE] && o_irq)
        else $error("Calibration interrupt not raised after capture.");

    a_done_sticky: assert property (
        (status_r[BIT_CAL_DONE] && !clr_done) |=> status_r[BIT_CAL_DONE])
        else $error("Done flag dropped without a clear.");

    a_capture_stable: assert property (
        !period_hit |=> $stable(sys_cap_r) && $stable(fast_cap_r))
        else $error("Captured values changed without a match.");

    // The system capture always equals the period that caused the match.
    a_capture_period: assert property (
        period_hit |=> (sys_cap_r == $past(period_r)))
        else $error("System capture differs from the matched period.");

    // The level output must follow the unmasked status in every cycle.
    a_irq_level: assert property (
        o_irq == |(status_r & mask_r))
        else $error("Interrupt output does not follow unmasked status.");

    // A match over an unserviced capture must leave the overrun mark behind.
    a_overrun_mark: assert property (
        (period_hit && status_r[BIT_CAL_DONE]) |=> status_r[BIT_OVERRUN])
        else $error("Repeated match did not mark an overrun.");

    // One pin rise must never count twice, so the edge pulse lasts a single cycle.
    a_edge_single: assert property (
        fast_edge |=> !fast_edge)
        else $error("Fast edge pulse lasted more than one cycle.");

endmodule

`default_nettype wire

//--- verilog/ccc_edge_sync.sv
// Two-flop synchroniser with rising edge detector for the fast capture clock pin.
`timescale 1ns/1ps
`default_nettype none

module ccc_edge_sync (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_async,
    output logic o_rise
);

    // Synchroniser chain; only meta2_r reads meta1_r.
    logic meta1_r;
    logic meta2_r;
    logic hist_r;
    logic rise_r;
    logic rise_nxt;

    // The detector looks at the second and third stages only, never the first.
    always_comb begin
        rise_nxt = meta2_r & ~hist_r;
    end

    // All stages clear to zero, so a high pin at release reads as one rising edge.
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta1_r <= 1'b0;
            meta2_r <= 1'b0;
            hist_r <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            meta1_r <= i_async;
            meta2_r <= meta1_r;
            hist_r <= meta2_r;
            rise_r <= rise_nxt;
        end
    end

    assign o_rise = rise_r;

endmodule

`default_nettype wire
